// [gate_driver_model.sv]
// Half-bridge gate driver model counting shoot-through cycles on leg 0
`timescale 1ns/10ps
module gate_driver_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Gate inputs
	input wire logic [5:0] pwm_pins,
	input wire logic arm,
	// Result
	output int shoots
);
	// Both switches on shorts the supply; only meaningful with dead band on
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			shoots <= 0;
		else if (arm && pwm_pins[0] === 1'b1 && pwm_pins[1] === 1'b1)
			shoots <= shoots + 1;
	end
endmodule : gate_driver_model

// [pwm_checker.sv]
// Port-level assertions for the three-generator PWM block
`timescale 1ns/10ps
module pwm_checker (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire pwm_pkg::bus_req_t bus,
	input wire logic [31:0] rdata,
	// Conditions and outputs
	input wire logic fault_in,
	input wire logic dbg_halt,
	input wire logic [5:0] pwm_pins,
	input wire logic [2:0] gen_irq,
	input wire logic [2:0] adc_trig,
	input wire logic fault_irq
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////
	AST_RDATA_IDLE:
		assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data not zero outside a read");
	AST_STATUS:
		assert property (bus.rd && bus.addr == 8'h20 |=> rdata == {31'h0, $past(fault_in)})
		else $error("status does not show the fault input");
	AST_UNMAPPED:
		assert property (bus.rd && bus.addr == 8'h3C |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_GLB_CMD_RD0:
		assert property (bus.rd && (bus.addr == 8'h00 || bus.addr == 8'h04) |=> rdata == 32'h0)
		else $error("command register reads nonzero");
	AST_COUNT_WIDTH:
		assert property (bus.rd && bus.addr[7:6] != 2'h0 && bus.addr[5:0] == 6'h14
			|=> rdata[31:16] == 16'h0)
		else $error("count wider than 16 bits");
	AST_RIS_WIDTH:
		assert property (bus.rd && bus.addr[7:6] != 2'h0 && bus.addr[5:0] == 6'h08
			|=> rdata[31:6] == 26'h0)
		else $error("event status wider than 6 bits");
	AST_FAULT_IRQ:
		assert property (fault_irq |-> $past(fault_in))
		else $error("fault interrupt without fault");
	AST_ENABLE_RD:
		assert property (bus.wr && bus.addr == 8'h08 ##1 bus.rd && bus.addr == 8'h08
			|=> rdata == {26'h0, $past(bus.wdata[5:0], 2)})
		else $error("enable register readback wrong");
endmodule : pwm_checker

bind pwm_top pwm_checker i_pwm_checker (.ref_clk, .rst, .bus, .rdata, .fault_in, .dbg_halt,
	.pwm_pins, .gen_irq, .adc_trig, .fault_irq);

// [pwm_map.svh]
// Register offsets, field positions, reset values and event indices of the PWM block
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH

`define GLB_CTL 6'h00
`define GLB_SYNC 6'h04
`define GLB_ENABLE 6'h08
`define GLB_INVERT 6'h0C
`define GLB_FAULT 6'h10
`define GLB_INTEN 6'h14
`define GLB_STATUS 6'h20

`define GEN_CTL 6'h00
`define GEN_INTEN 6'h04
`define GEN_RIS 6'h08
`define GEN_LOAD 6'h10
`define GEN_COUNT 6'h14
`define GEN_CMPA 6'h18
`define GEN_CMPB 6'h1C
`define GEN_GENA 6'h20
`define GEN_GENB 6'h24
`define GEN_DBCTL 6'h28
`define GEN_DBRISE 6'h2C
`define GEN_DBFALL 6'h30

`define CTL_ENABLE 0
`define CTL_UPDOWN 1
`define CTL_SYNCUPD 2
`define CTL_DBGRUN 3
`define INTEN_TRIG_LSB 8

`define EV_ZERO 0
`define EV_LOAD 1
`define EV_AUP 2
`define EV_ADN 3
`define EV_BUP 4
`define EV_BDN 5

`define ACT_KEEP 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_LOW 2'h2
`define ACT_HIGH 2'h3

`define RST_WORD16 16'h0000
`define RST_DELAY 12'h000

`endif

// [pwm_pkg.sv]
// Types shared by the PWM block
package pwm_pkg;

	typedef struct packed {
		logic en;
		logic updown;
		logic sync_upd;
		logic dbg_run;
		logic [5:0] irq_sel;
		logic [5:0] trig_sel;
		logic [15:0] load_sh;
		logic [15:0] load;
		logic [15:0] cmpa_sh;
		logic [15:0] cmpa;
		logic [15:0] cmpb_sh;
		logic [15:0] cmpb;
		logic [11:0] gena;
		logic [11:0] genb;
		logic db_en;
		logic [11:0] rise;
		logic [11:0] fall;
		logic [15:0] cnt;
		logic dir;
		logic armed;
		logic pwm_a;
		logic pwm_b;
		logic db_prev;
		logic [11:0] rcnt;
		logic [11:0] fcnt;
		logic db0;
		logic db1;
		logic [5:0] ris;
		logic irq;
		logic trig;
	} gen_t;

	typedef struct packed {
		gen_t [2:0] g;
		logic [5:0] out_en;
		logic [5:0] inv;
		logic [5:0] fmask;
		logic fint_en;
		logic [5:0] pins;
		logic fault_irq;
		logic [31:0] rdata;
	} state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

endpackage : pwm_pkg

// [pwm_top.sv]
// Three-generator PWM block with dead band, event selectors and output control
//
// Contract
// - Three generators, each: 16-bit counter, two comparators, signal gen, dead band, selector.
// - Down mode counts load to zero, reloads, keeps counting down.
// - Up/down mode counts zero to load and back, continuously.
// - Direction low in down mode; follows count direction in up/down mode.
// - One-clock pulses at zero and at load; load pulse follows zero in down mode.
// - Comparator match pulses, qualified by direction into up and down matches.
// - Match value above load never matches.
// - Four events in down mode, six in up/down mode drive the outputs.
// - Matches coinciding with zero or load are ignored.
// - On coinciding matches, first output uses A only, second uses B only.
// - Per event and output: keep, toggle, drive low or drive high.
// - Dead band off passes both; on, first output delays input rising edge.
// - Dead band on, second output is inverted input, rise delayed after input fall.
// - Generator interrupt on any event of a selected set.
// - ADC trigger pulse on any event of a second selected set.
// - Interrupt and trigger use raw counter events, not dead-band edges.
// - Global control synchronously resets any chosen subset of counters.
// - Immediate mode: new load or compare value takes effect at next zero.
// - Sync mode: new values wait for global update, then next zero; per generator.
// - Per-output fault bit forces inactive under fault; fault may interrupt.
// - Debug stall: keep running or run to zero then stop; no interrupt.
// - Output stage: per-signal enable in one register, optional inversion.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "pwm_map.svh"

module pwm_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire pwm_pkg::bus_req_t bus,
	output logic [31:0] rdata,
	// External conditions
	input wire logic fault_in,
	input wire logic dbg_halt,
	// Pins and events
	output logic [5:0] pwm_pins,
	output logic [2:0] gen_irq,
	output logic [2:0] adc_trig,
	output logic fault_irq
);

	pwm_pkg::state_t s_ff;
	pwm_pkg::state_t nxt_s;
	logic [2:0] sync_rst;
	logic upd_req;
	logic [5:0] ev;
	logic [5:0] raw;
	logic z;
	logic l;
	logic am;
	logic bm;
	logic run;
	logic take;
	logic [15:0] nl;
	logic [1:0] gsel;
	logic [5:0] off;
	logic x;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Event code of one event from a 12-bit action register
	function automatic logic [1:0] code_of(input logic [11:0] act, input int idx);
		return act[2*idx +: 2];
	endfunction : code_of

	// Match only while the compare value lies inside the count range
	function automatic logic hit(input logic [15:0] cmp, input logic [15:0] ld,
		input logic [15:0] cnt);
		return cmp <= ld && cnt == cmp;
	endfunction : hit

	// First firing event wins: zero, load, own match, other match
	function automatic logic [1:0] pick(input logic [11:0] act, input logic [5:0] e,
		input logic b_side);
		logic [1:0] c;
		c = `ACT_KEEP;
		if (e[`EV_ZERO])
			c = code_of(act, `EV_ZERO);
		else if (e[`EV_LOAD])
			c = code_of(act, `EV_LOAD);
		else if (!b_side && (e[`EV_AUP] || e[`EV_ADN]))
			c = e[`EV_AUP] ? code_of(act, `EV_AUP) : code_of(act, `EV_ADN);
		else if (b_side && (e[`EV_BUP] || e[`EV_BDN]))
			c = e[`EV_BUP] ? code_of(act, `EV_BUP) : code_of(act, `EV_BDN);
		else if (e[`EV_AUP] || e[`EV_ADN])
			c = e[`EV_AUP] ? code_of(act, `EV_AUP) : code_of(act, `EV_ADN);
		else if (e[`EV_BUP] || e[`EV_BDN])
			c = e[`EV_BUP] ? code_of(act, `EV_BUP) : code_of(act, `EV_BDN);
		return c;
	endfunction : pick

	function automatic logic apply(input logic cur, input logic [1:0] c);
		logic v;
		v = cur;
		unique case (c)
			`ACT_KEEP: v = cur;
			`ACT_TOGGLE: v = ~cur;
			`ACT_LOW: v = 1'b0;
			`ACT_HIGH: v = 1'b1;
		endcase
		return v;
	endfunction : apply

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.rdata = 32'h00000000;
		sync_rst = 3'h0;
		upd_req = 1'b0;
		ev = 6'h00;
		raw = 6'h00;
		z = 1'b0;
		l = 1'b0;
		am = 1'b0;
		bm = 1'b0;
		run = 1'b0;
		take = 1'b0;
		nl = `RST_WORD16;
		x = 1'b0;
		gsel = bus.addr[7:6];
		off = bus.addr[5:0];

		// Global registers
		if (gsel == 2'h0)
		begin
			if (bus.wr)
			begin
				unique case (off)
					`GLB_CTL: upd_req = bus.wdata[0];
					`GLB_SYNC: sync_rst = bus.wdata[2:0];
					`GLB_ENABLE: nxt_s.out_en = bus.wdata[5:0];
					`GLB_INVERT: nxt_s.inv = bus.wdata[5:0];
					`GLB_FAULT: nxt_s.fmask = bus.wdata[5:0];
					`GLB_INTEN: nxt_s.fint_en = bus.wdata[0];
					default: ;
				endcase
			end
			if (bus.rd)
			begin
				unique case (off)
					`GLB_ENABLE: nxt_s.rdata = {26'h0000000, s_ff.out_en};
					`GLB_INVERT: nxt_s.rdata = {26'h0000000, s_ff.inv};
					`GLB_FAULT: nxt_s.rdata = {26'h0000000, s_ff.fmask};
					`GLB_INTEN: nxt_s.rdata = {31'h00000000, s_ff.fint_en};
					`GLB_STATUS: nxt_s.rdata = {31'h00000000, fault_in};
					default: nxt_s.rdata = 32'h00000000;
				endcase
			end
		end

		for (int i = 0; i < 3; i++)
		begin
			// Load and compare writes land in shadow copies; other fields take effect directly
			if (bus.wr && gsel == 2'(i + 1))
			begin
				unique case (off)
					`GEN_CTL:
					begin
						nxt_s.g[i].en = bus.wdata[`CTL_ENABLE];
						nxt_s.g[i].updown = bus.wdata[`CTL_UPDOWN];
						nxt_s.g[i].sync_upd = bus.wdata[`CTL_SYNCUPD];
						nxt_s.g[i].dbg_run = bus.wdata[`CTL_DBGRUN];
					end
					`GEN_INTEN:
					begin
						nxt_s.g[i].irq_sel = bus.wdata[5:0];
						nxt_s.g[i].trig_sel = bus.wdata[`INTEN_TRIG_LSB +: 6];
					end
					`GEN_LOAD: nxt_s.g[i].load_sh = bus.wdata[15:0];
					`GEN_CMPA: nxt_s.g[i].cmpa_sh = bus.wdata[15:0];
					`GEN_CMPB: nxt_s.g[i].cmpb_sh = bus.wdata[15:0];
					`GEN_GENA: nxt_s.g[i].gena = bus.wdata[11:0];
					`GEN_GENB: nxt_s.g[i].genb = bus.wdata[11:0];
					`GEN_DBCTL: nxt_s.g[i].db_en = bus.wdata[0];
					`GEN_DBRISE: nxt_s.g[i].rise = bus.wdata[11:0];
					`GEN_DBFALL: nxt_s.g[i].fall = bus.wdata[11:0];
					default: ;
				endcase
			end
			if (bus.rd && gsel == 2'(i + 1))
			begin
				unique case (off)
					`GEN_CTL: nxt_s.rdata = {28'h0000000, s_ff.g[i].dbg_run,
						s_ff.g[i].sync_upd, s_ff.g[i].updown, s_ff.g[i].en};
					`GEN_INTEN: nxt_s.rdata = {18'h00000, s_ff.g[i].trig_sel,
						2'h0, s_ff.g[i].irq_sel};
					`GEN_RIS: nxt_s.rdata = {26'h0000000, s_ff.g[i].ris};
					`GEN_LOAD: nxt_s.rdata = {16'h0000, s_ff.g[i].load_sh};
					`GEN_COUNT: nxt_s.rdata = {16'h0000, s_ff.g[i].cnt};
					`GEN_CMPA: nxt_s.rdata = {16'h0000, s_ff.g[i].cmpa_sh};
					`GEN_CMPB: nxt_s.rdata = {16'h0000, s_ff.g[i].cmpb_sh};
					`GEN_GENA: nxt_s.rdata = {20'h00000, s_ff.g[i].gena};
					`GEN_GENB: nxt_s.rdata = {20'h00000, s_ff.g[i].genb};
					`GEN_DBCTL: nxt_s.rdata = {31'h00000000, s_ff.g[i].db_en};
					`GEN_DBRISE: nxt_s.rdata = {20'h00000, s_ff.g[i].rise};
					`GEN_DBFALL: nxt_s.rdata = {20'h00000, s_ff.g[i].fall};
					default: nxt_s.rdata = 32'h00000000;
				endcase
			end

			// Counter events
			z = s_ff.g[i].cnt == `RST_WORD16;
			l = s_ff.g[i].cnt == s_ff.g[i].load;
			am = hit(s_ff.g[i].cmpa, s_ff.g[i].load, s_ff.g[i].cnt);
			bm = hit(s_ff.g[i].cmpb, s_ff.g[i].load, s_ff.g[i].cnt);
			// Stall stops only once the count sits at zero
			run = s_ff.g[i].en && !(dbg_halt && !s_ff.g[i].dbg_run && z);
			ev = 6'h00;
			if (run)
			begin
				ev[`EV_ZERO] = z;
				ev[`EV_LOAD] = l;
				ev[`EV_AUP] = am && s_ff.g[i].dir && !(z || l);
				ev[`EV_ADN] = am && !s_ff.g[i].dir && !(z || l);
				ev[`EV_BUP] = bm && s_ff.g[i].dir && !(z || l);
				ev[`EV_BDN] = bm && !s_ff.g[i].dir && !(z || l);
			end

			// Parameter update at zero, gated by the armed flag in sync mode
			take = run && z && (!s_ff.g[i].sync_upd || s_ff.g[i].armed);
			nxt_s.g[i].armed = (upd_req && s_ff.g[i].sync_upd)
				|| (s_ff.g[i].armed && !take);
			nl = take ? s_ff.g[i].load_sh : s_ff.g[i].load;
			if (take)
			begin
				nxt_s.g[i].load = s_ff.g[i].load_sh;
				nxt_s.g[i].cmpa = s_ff.g[i].cmpa_sh;
				nxt_s.g[i].cmpb = s_ff.g[i].cmpb_sh;
			end

			// Counter
			if (sync_rst[i])
			begin
				nxt_s.g[i].cnt = `RST_WORD16;
				nxt_s.g[i].dir = s_ff.g[i].updown;
			end
			else if (run && !s_ff.g[i].updown)
			begin
				nxt_s.g[i].dir = 1'b0;
				nxt_s.g[i].cnt = z ? nl : s_ff.g[i].cnt - 16'h0001;
			end
			else if (run && s_ff.g[i].dir)
			begin
				if (s_ff.g[i].cnt >= nl)
				begin
					nxt_s.g[i].dir = 1'b0;
					nxt_s.g[i].cnt = z ? s_ff.g[i].cnt : s_ff.g[i].cnt - 16'h0001;
				end
				else
					nxt_s.g[i].cnt = s_ff.g[i].cnt + 16'h0001;
			end
			else if (run)
			begin
				if (z)
				begin
					nxt_s.g[i].dir = 1'b1;
					nxt_s.g[i].cnt = (nl != `RST_WORD16) ? 16'h0001 : `RST_WORD16;
				end
				else
					nxt_s.g[i].cnt = s_ff.g[i].cnt - 16'h0001;
			end

			// Signal generator
			nxt_s.g[i].pwm_a = apply(s_ff.g[i].pwm_a, pick(s_ff.g[i].gena, ev, 1'b0));
			nxt_s.g[i].pwm_b = apply(s_ff.g[i].pwm_b, pick(s_ff.g[i].genb, ev, 1'b1));

			// Selectors see raw events, never the dead-band edges
			nxt_s.g[i].ris = ev;
			nxt_s.g[i].irq = |(ev & s_ff.g[i].irq_sel);
			nxt_s.g[i].trig = |(ev & s_ff.g[i].trig_sel);

			// Dead band: either edge of the input reloads the pending delay
			x = s_ff.g[i].pwm_a;
			nxt_s.g[i].db_prev = x;
			if (!x)
			begin
				nxt_s.g[i].db0 = 1'b0;
				nxt_s.g[i].rcnt = `RST_DELAY;
			end
			else if (!s_ff.g[i].db_prev)
			begin
				nxt_s.g[i].rcnt = s_ff.g[i].rise;
				nxt_s.g[i].db0 = s_ff.g[i].rise == `RST_DELAY;
			end
			else if (s_ff.g[i].rcnt != `RST_DELAY)
			begin
				// Rise with the last count step, so a delay of n always gives n+1 clocks
				nxt_s.g[i].rcnt = s_ff.g[i].rcnt - 12'h001;
				nxt_s.g[i].db0 = s_ff.g[i].rcnt == 12'h001;
			end
			else
				nxt_s.g[i].db0 = 1'b1;
			if (x)
			begin
				nxt_s.g[i].db1 = 1'b0;
				nxt_s.g[i].fcnt = `RST_DELAY;
			end
			else if (s_ff.g[i].db_prev)
			begin
				nxt_s.g[i].fcnt = s_ff.g[i].fall;
				nxt_s.g[i].db1 = s_ff.g[i].fall == `RST_DELAY;
			end
			else if (s_ff.g[i].fcnt != `RST_DELAY)
			begin
				nxt_s.g[i].fcnt = s_ff.g[i].fcnt - 12'h001;
				nxt_s.g[i].db1 = s_ff.g[i].fcnt == 12'h001;
			end
			else
				nxt_s.g[i].db1 = 1'b1;

			raw[2*i] = s_ff.g[i].db_en ? s_ff.g[i].db0 : s_ff.g[i].pwm_a;
			raw[2*i+1] = s_ff.g[i].db_en ? s_ff.g[i].db1 : s_ff.g[i].pwm_b;
		end

		// Inactive is low before inversion, so an inverted pin idles high
		nxt_s.pins = (raw & s_ff.out_en & ~(s_ff.fmask & {6{fault_in}})) ^ s_ff.inv;
		nxt_s.fault_irq = fault_in && s_ff.fint_en;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign rdata = s_ff.rdata;
	assign pwm_pins = s_ff.pins;
	assign fault_irq = s_ff.fault_irq;
	assign gen_irq = {s_ff.g[2].irq, s_ff.g[1].irq, s_ff.g[0].irq};
	assign adc_trig = {s_ff.g[2].trig, s_ff.g[1].trig, s_ff.g[0].trig};

endmodule : pwm_top

// [three_generator_pwm_module_tb.sv]
// Self-checking testbench of the PWM block
`timescale 1ns/10ps
`include "pwm_map.svh"
module three_generator_pwm_module_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	pwm_pkg::bus_req_t bus = '0;
	logic fault_in = 1'b0;
	logic dbg_halt = 1'b0;
	logic arm = 1'b0;
	logic [31:0] rdata;
	logic [5:0] pwm_pins;
	logic [2:0] gen_irq;
	logic [2:0] adc_trig;
	logic fault_irq;
	int shoots;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	int hp[6];
	int hi[3];
	int ht[3];
	pwm_top i_pwm_top (.ref_clk, .rst, .bus, .rdata, .fault_in, .dbg_halt, .pwm_pins,
		.gen_irq, .adc_trig, .fault_irq);
	gate_driver_model i_gate_driver_model (.ref_clk, .rst, .pwm_pins, .arm, .shoots);
	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////
	function automatic logic [7:0] ga(input int g, input logic [5:0] o);
		return {2'(g + 1), o};
	endfunction : ga
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// Leaves the strobe up; the next rd or watch call lowers it
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{a, d, 1'b1, 1'b0};
	endtask : wr
	task rd(input string s, input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1;
		chk(s, e, rdata);
	endtask : rd
	task watch(input int n);
		hp = '{default: 0};
		hi = '{default: 0};
		ht = '{default: 0};
		repeat (n)
		begin
			@(posedge ref_clk);
			bus <= '0;
			#1;
			for (int i = 0; i < 6; i++)
				hp[i] += int'(pwm_pins[i] === 1'b1);
			for (int i = 0; i < 3; i++)
			begin
				hi[i] += int'(gen_irq[i] === 1'b1);
				ht[i] += int'(adc_trig[i] === 1'b1);
			end
		end
	endtask : watch
	task stop_test();
		$display("checked %0d failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	////////////////////////////////////////
	task t_reset();
		rd("load", ga(0, `GEN_LOAD), 32'h0);
		rd("ris", ga(0, `GEN_RIS), 32'h0);
		rd("sync", 8'h04, 32'h0);
		rd("unmapped", 8'h3C, 32'h0);
		chk("pins", 32'h0, pwm_pins);
		$display("test reset done");
	endtask : t_reset
	task t_down();
		wr(ga(0, `GEN_INTEN), 32'h0201);
		wr(ga(0, `GEN_LOAD), 32'h3);
		wr(ga(0, `GEN_CTL), 32'h1);
		watch(20);
		watch(16);
		chk("zero irq", 32'd4, hi[0]);
		chk("load trig", 32'd4, ht[0]);
		for (int i = 0; i < 8 && gen_irq[0] !== 1'b1; i++)
			watch(1);
		watch(1);
		chk("load after zero", 32'h1, adc_trig[0]);
		$display("test down done");
	endtask : t_down
	task t_updown();
		wr(ga(1, `GEN_INTEN), 32'h0401);
		wr(ga(1, `GEN_LOAD), 32'h4);
		wr(ga(1, `GEN_CMPA), 32'h2);
		wr(ga(1, `GEN_CTL), 32'h3);
		wr(ga(2, `GEN_INTEN), 32'h30);
		wr(ga(2, `GEN_LOAD), 32'h3);
		wr(ga(2, `GEN_CMPB), 32'h5);
		wr(ga(2, `GEN_CTL), 32'h3);
		watch(20);
		watch(32);
		chk("updown zero", 32'd4, hi[1]);
		chk("a up trig", 32'd4, ht[1]);
		chk("b above load", 32'd0, hi[2]);
		$display("test updown done");
	endtask : t_updown
	task t_wave();
		wr(ga(0, `GEN_GENA), 32'h83);
		wr(ga(0, `GEN_CMPA), 32'h1);
		wr(8'h08, 32'h1);
		rd("enable", 8'h08, 32'h1);
		watch(20);
		watch(16);
		chk("pin0 high", 32'd12, hp[0]);
		chk("pin1 off", 32'd0, hp[1]);
		wr(8'h0C, 32'h1);
		watch(1);
		watch(16);
		chk("pin0 inv", 32'd4, hp[0]);
		wr(8'h10, 32'h1);
		wr(8'h14, 32'h1);
		fault_in <= 1'b1;
		watch(16);
		chk("fault pin", 32'd16, hp[0]);
		chk("fault irq", 32'h1, fault_irq);
		rd("status", 8'h20, 32'h1);
		fault_in <= 1'b0;
		wr(8'h0C, 32'h0);
		wr(8'h10, 32'h0);
		$display("test wave done");
	endtask : t_wave
	task t_deadband();
		wr(ga(0, `GEN_LOAD), 32'h9);
		wr(ga(0, `GEN_CMPA), 32'h4);
		wr(ga(0, `GEN_DBRISE), 32'h2);
		wr(ga(0, `GEN_DBFALL), 32'h2);
		wr(ga(0, `GEN_DBCTL), 32'h1);
		wr(8'h08, 32'h3);
		watch(30);
		arm <= 1'b1;
		watch(40);
		chk("db first", 32'd16, hp[0]);
		chk("db second", 32'd8, hp[1]);
		chk("shoot", 32'd0, shoots);
		arm <= 1'b0;
		wr(ga(0, `GEN_DBCTL), 32'h0);
		watch(10);
		watch(20);
		chk("bypass first", 32'd12, hp[0]);
		chk("bypass second", 32'd0, hp[1]);
		$display("test deadband done");
	endtask : t_deadband
	task t_sync();
		wr(ga(1, `GEN_CTL), 32'h1);
		wr(ga(1, `GEN_LOAD), 32'h9);
		wr(ga(1, `GEN_INTEN), 32'h1);
		watch(30);
		wr(8'h04, 32'h3);
		watch(3);
		for (int i = 0; i < 20; i++)
		begin
			watch(1);
			chk("sync irq", gen_irq[0], gen_irq[1]);
		end
		wr(ga(0, `GEN_CTL), 32'h5);
		wr(ga(0, `GEN_LOAD), 32'h3);
		watch(30);
		chk("held load", 32'd3, hi[0]);
		wr(8'h00, 32'h1);
		watch(20);
		watch(20);
		chk("new load", 32'd5, hi[0]);
		$display("test sync done");
	endtask : t_sync
	task t_stall();
		wr(ga(0, `GEN_CTL), 32'h1);
		dbg_halt <= 1'b1;
		watch(20);
		rd("stall count", ga(0, `GEN_COUNT), 32'h0);
		wr(ga(0, `GEN_CTL), 32'h9);
		watch(10);
		watch(20);
		chk("stall run", 32'd5, hi[0]);
		dbg_halt <= 1'b0;
		$display("test stall done");
	endtask : t_stall
	////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_down();
		t_updown();
		t_wave();
		t_deadband();
		t_sync();
		t_stall();
		stop_test();
	end
	// Whole run is well under a thousand cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			stop_test();
		end
	end
endmodule : three_generator_pwm_module_tb
